//--- rtl/pbtl_pkg.sv
package pbtl_pkg;
	// Clock and timer base
	localparam int unsigned CLOCK_PERIOD_NS = 4;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
	localparam int unsigned MS_PER_SECOND = 1000;
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned NUM_OBJ = 3;

	// Register byte addresses and object regions (PADDR[7:4])
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SIMPLE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [3:0] REGION_OBJ_CFG = 4'h1;
	localparam logic [3:0] REGION_OBJ_PRESS = 4'h2;
	localparam logic [3:0] REGION_OBJ_RELEASE = 4'h3;
	localparam logic [3:0] REGION_OBJ_STATE = 4'h4;

	// Reset values
	localparam logic [31:0] CTRL_RESET = 32'h0c05_0300;
	localparam logic [31:0] SIMPLE_RESET = 32'h0000_0043;
	localparam logic [31:0] OBJ_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] OBJ_VAL_RESET = 32'h0000_0000;

	// Time units in seconds
	localparam logic [16:0] UNIT_SECOND = 17'h00001;
	localparam logic [16:0] UNIT_MINUTE = 17'h0003c;
	localparam logic [16:0] UNIT_HOUR = 17'h00e10;
	localparam logic [16:0] UNIT_DAY = 17'h15180;

	// Long-press table: 300..900 ms in 100 ms steps, then 1..10 s
	localparam int unsigned LP_MIN_MS = 300;
	localparam int unsigned LP_STEP_MS = 100;
	localparam int unsigned LP_LAST_SUB = 6;
	localparam int unsigned LP_LAST_SEL = 16;
	localparam int unsigned LP_MAX_MS = 10000;

	// Four-bit dimming command layout
	localparam int unsigned DIM_DIR_BIT = 3;
	localparam logic [2:0] DIM_STEP_START = 3'h1;
	localparam logic [2:0] DIM_STEP_BREAK = 3'h0;

	typedef enum logic [3:0] {
		DTYPE_UNUSED = 4'h0, DTYPE_SWITCH = 4'h1, DTYPE_UPDOWN = 4'h2, DTYPE_STEP = 4'h3,
		DTYPE_TRIGGER = 4'h4, DTYPE_PRIORITY = 4'h5, DTYPE_DIMMING = 4'h6, DTYPE_SCENE = 4'h7,
		DTYPE_PERCENT = 4'h8, DTYPE_U8 = 4'h9, DTYPE_S8 = 4'ha, DTYPE_U32 = 4'hb,
		DTYPE_U16 = 4'hc, DTYPE_F16 = 4'hd, DTYPE_F32 = 4'he
	} pbtl_data_point_type_t;
	typedef enum logic [2:0] {
		FUNC_SWITCH = 3'h0, FUNC_DIM = 3'h1, FUNC_BLIND = 3'h2, FUNC_SCENE = 3'h3,
		FUNC_VALUE = 3'h4
	} pbtl_func_t;
	typedef enum logic [1:0] {
		TU_SECOND = 2'h0, TU_MINUTE = 2'h1, TU_HOUR = 2'h2, TU_DAY = 2'h3
	} pbtl_unit_t;
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0, ACT_OFF = 2'h1, ACT_ON = 2'h2, ACT_TOGGLE = 2'h3
	} pbtl_sw_act_t;
	typedef enum logic [2:0] {
		DIM_ON_BRIGHTER = 3'h0, DIM_TOGGLE_BRIGHTER = 3'h1, DIM_OFF_DARKER = 3'h2,
		DIM_TOGGLE_DARKER = 3'h3, DIM_TOGGLE_ALTERNATE = 3'h4
	} pbtl_dim_react_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_HELD = 2'b01, ST_LONG = 2'b10
	} pbtl_press_state_t;

	typedef struct packed {
		logic rsv;
		logic [4:0] long_sel;
		logic [7:0] cyc_value;
		pbtl_unit_t cyc_unit;
		logic [7:0] blk_value;
		pbtl_unit_t blk_unit;
		logic blk_en;
		logic cyc_en;
		logic advanced;
		pbtl_func_t func;
	} pbtl_ctrl_t;
	typedef struct packed {
		logic [24:0] rsv;
		pbtl_dim_react_t dim_react;
		pbtl_sw_act_t release_act;
		pbtl_sw_act_t press_act;
	} pbtl_simple_t;
	typedef struct packed {
		logic [21:0] rsv;
		logic release_cyclic;
		logic release_toggle;
		logic release_send;
		logic press_cyclic;
		logic press_toggle;
		logic press_send;
		pbtl_data_point_type_t dtype;
	} pbtl_obj_cfg_t;
	typedef struct packed {
		logic [1:0] obj;
		pbtl_data_point_type_t dtype;
		logic cyclic_repeat;
		logic [31:0] value;
	} pbtl_telegram_t;
endpackage

//--- rtl/pbtl_debounce.sv
`timescale 1ns/100ps
module pbtl_debounce #(
	parameter int unsigned DEBOUNCE_MS_P = pbtl_pkg::DEBOUNCE_MS
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic ms_tick,
	input wire logic raw,
	output logic level
);
	import pbtl_pkg::*;
	logic sync1;
	logic sync2;
	logic sync3;
	logic [7:0] count;

	// Three-stage synchroniser; only sync2 and sync3 are compared
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// New level must stay stable for the whole debounce time, else restart
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count <= 8'h00;
			level <= 1'b0;
		end else if (sync2 != sync3 || sync3 == level) begin
			count <= 8'h00;
		end else if (ms_tick) begin
			if (count >= 8'(DEBOUNCE_MS_P - 1)) begin
				level <= sync3;
				count <= 8'h00;
			end else begin
				count <= count + 8'h01;
			end
		end
	end
endmodule

//--- rtl/pbtl_top.sv
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// R1: Each object carries a data type from the fifteen listed kinds.
// R2: A configured event sends a telegram only when sending is enabled.
// R3: Toggle value inverts the present value of bit and dimming kinds and sends it; wider kinds send the set value.
// R4: Alternating dimming inverts stored direction bit and sends that.
// R5: Cyclic events repeat their telegram every cycle period when enabled globally.
// R6: Start-up blocking ignores the input for the blocking time, else immediate.
// R7: Blocking time is count 1..255 (default 3) times second/minute/hour/day.
// R8: Each input takes exactly one task which picks the object behaviour.
// R9: Simple mode uses fixed reactions; advanced allows up to three objects.
// R10: Simple switching press sends nothing, off, on or toggled value.
// R11: Simple switching release independently sends nothing, off, on or toggle.
// R12: Simple dimming short press switches; long press start sends dim command.
// R13: Simple dimming always sends a dim break when a long press ends.
// R14: Press held beyond long-press time (300 ms..10 s, 600 default) is long.
// R15: Alternating dimming reverses direction on each successive long press.
// R16: Cycle period is a configured count times a selectable time unit.
// R17: Press and release come from edges of the debounced input level.
// R18: All timers run from a one millisecond tick and idle at reset.
module pbtl_top #(
	parameter int unsigned TICK_CYCLES_P = pbtl_pkg::TICK_CYCLES,
	parameter int unsigned MS_PER_SECOND_P = pbtl_pkg::MS_PER_SECOND,
	parameter int unsigned DEBOUNCE_MS_P = pbtl_pkg::DEBOUNCE_MS,
	parameter logic [31:0] CTRL_INIT = pbtl_pkg::CTRL_RESET
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic BUTTON_IN,
	output logic TX_VALID,
	input wire logic TX_READY,
	output pbtl_pkg::pbtl_telegram_t TX_TELEGRAM
);
	import pbtl_pkg::*;
	localparam int TW = (TICK_CYCLES_P > 1) ? $clog2(TICK_CYCLES_P) : 1;

	pbtl_ctrl_t ctrl;
	pbtl_simple_t simple;
	pbtl_obj_cfg_t obj_cfg [NUM_OBJ];
	logic [31:0] obj_press_val [NUM_OBJ];
	logic [31:0] obj_rel_val [NUM_OBJ];
	logic [31:0] obj_value [NUM_OBJ];
	pbtl_data_point_type_t dtype_eff [NUM_OBJ];
	logic [NUM_OBJ-1:0] fire, cyc_fire, cyc_armed, pending, pend_rep;
	logic [TW-1:0] tick_cnt;
	logic ms_tick, sec_tick, level, level_q, eval_on, long_hit, load;
	logic [9:0] ms_cnt;
	logic [24:0] elapsed_s, blk_limit, cyc_limit;
	logic [13:0] press_ms, lp_ms;
	pbtl_press_state_t state, next_state;
	logic ev_press, ev_release, ev_short, ev_long_start, ev_long_end;
	logic [1:0] sel;
	logic [3:0] region;
	logic [1:0] idx;
	logic idx_ok, hit, ro, wr_en;
	logic [31:0] rdata, status_word;

	function automatic logic [16:0] unit_s(input pbtl_unit_t u);
		case (u)
			TU_SECOND: return UNIT_SECOND;
			TU_MINUTE: return UNIT_MINUTE;
			TU_HOUR: return UNIT_HOUR;
			default: return UNIT_DAY;
		endcase
	endfunction

	function automatic logic [13:0] lp_ms_of(input logic [4:0] s);
		logic [13:0] w;
		w = 14'(s);
		if (s <= 5'(LP_LAST_SUB)) return 14'(LP_MIN_MS) + w * 14'(LP_STEP_MS);
		else if (s <= 5'(LP_LAST_SEL)) return (w - 14'(LP_LAST_SUB)) * 14'(MS_PER_SECOND);
		else return 14'(LP_MAX_MS);
	endfunction

	// Inversion only makes sense for bit kinds and the dimming direction bit; other kinds send the set value
	function automatic logic [31:0] toggled(input pbtl_data_point_type_t dt,
		input logic [31:0] cur, input logic [31:0] cfgv);
		case (dt)
			DTYPE_DIMMING: return {28'h0, ~cur[DIM_DIR_BIT], cfgv[2:0]};
			DTYPE_SWITCH, DTYPE_UPDOWN, DTYPE_STEP, DTYPE_TRIGGER: return {31'h0, ~cur[0]};
			default: return cfgv;
		endcase
	endfunction

	// Returns {send, value} for a simple switching action
	function automatic logic [32:0] sw_act(input pbtl_sw_act_t a, input logic [31:0] cur);
		case (a)
			ACT_OFF: return {1'b1, 32'h0};
			ACT_ON: return {1'b1, 32'h1};
			ACT_TOGGLE: return {1'b1, 31'h0, ~cur[0]};
			default: return {1'b0, cur};
		endcase
	endfunction

	// Millisecond tick and second tick for all timers
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end else if (tick_cnt == TW'(TICK_CYCLES_P - 1)) begin
			tick_cnt <= '0;
			ms_tick <= 1'b1; // R18
		end else begin
			tick_cnt <= tick_cnt + TW'(1);
			ms_tick <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			ms_cnt <= 10'h000;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= 1'b0;
			if (ms_tick) begin
				if (ms_cnt == 10'(MS_PER_SECOND_P - 1)) begin
					ms_cnt <= 10'h000;
					sec_tick <= 1'b1;
				end else begin
					ms_cnt <= ms_cnt + 10'h001;
				end
			end
		end
	end

	// APB decode; zero wait states, unknown or read-only writes flag an error
	assign region = PADDR[7:4];
	assign idx = PADDR[3:2];
	assign idx_ok = (idx < 2'(NUM_OBJ)) && (PADDR[1:0] == 2'b00);
	assign status_word = {22'h0, cyc_armed, pending, state, level, eval_on};
	always_comb begin
		hit = 1'b0;
		ro = 1'b0;
		rdata = 32'h0;
		if (PADDR == ADDR_CTRL) begin
			hit = 1'b1;
			rdata = ctrl;
		end else if (PADDR == ADDR_SIMPLE) begin
			hit = 1'b1;
			rdata = simple;
		end else if (PADDR == ADDR_STATUS) begin
			hit = 1'b1;
			ro = 1'b1;
			rdata = status_word;
		end else if (idx_ok) begin
			hit = 1'b1;
			case (region)
				REGION_OBJ_CFG: rdata = obj_cfg[idx];
				REGION_OBJ_PRESS: rdata = obj_press_val[idx];
				REGION_OBJ_RELEASE: rdata = obj_rel_val[idx];
				REGION_OBJ_STATE: begin
					ro = 1'b1;
					rdata = obj_value[idx];
				end
				default: hit = 1'b0;
			endcase
		end
	end
	assign PREADY = 1'b1;
	assign wr_en = PSEL && PENABLE && PWRITE && hit && !ro;

	// Read data captured in the setup cycle so it comes from flops
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			PRDATA <= PWRITE ? 32'h0 : rdata;
			PSLVERR <= !hit || (PWRITE && ro);
		end
	end

	// Configuration registers
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			ctrl <= CTRL_INIT;
			simple <= SIMPLE_RESET;
			for (int i = 0; i < NUM_OBJ; i++) begin
				obj_cfg[i] <= OBJ_CFG_RESET;
				obj_press_val[i] <= OBJ_VAL_RESET;
				obj_rel_val[i] <= OBJ_VAL_RESET;
			end
		end else if (wr_en) begin
			if (PADDR == ADDR_CTRL) ctrl <= PWDATA; // R8 R9 R7 R16
			else if (PADDR == ADDR_SIMPLE) simple <= PWDATA;
			else if (region == REGION_OBJ_CFG) obj_cfg[idx] <= PWDATA; // R1
			else if (region == REGION_OBJ_PRESS) obj_press_val[idx] <= PWDATA;
			else if (region == REGION_OBJ_RELEASE) obj_rel_val[idx] <= PWDATA;
		end
	end

	pbtl_debounce #(
		.DEBOUNCE_MS_P(DEBOUNCE_MS_P)
	) u_debounce (
		.clock(CLOCK),
		.reset(RESET),
		.ms_tick(ms_tick),
		.raw(BUTTON_IN),
		.level(level)
	);

	// Start-up blocking; once evaluation starts it never stops again
	assign blk_limit = 25'(ctrl.blk_value) * 25'(unit_s(ctrl.blk_unit)); // R7
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			elapsed_s <= 25'h0;
			eval_on <= 1'b0;
		end else begin
			if (sec_tick && elapsed_s != 25'h1ffffff) elapsed_s <= elapsed_s + 25'h1;
			if (!ctrl.blk_en || elapsed_s >= blk_limit) eval_on <= 1'b1; // R6
		end
	end

	// Edges of the debounced level; level_q tracks even while blocked
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) level_q <= 1'b0;
		else level_q <= level;
	end
	assign ev_press = eval_on && level && !level_q; // R17
	assign ev_release = eval_on && !level && level_q; // R17

	// Short / long press classification
	assign lp_ms = lp_ms_of(ctrl.long_sel);
	assign long_hit = ms_tick && (press_ms == lp_ms); // R14
	assign ev_short = (state == ST_HELD) && ev_release;
	assign ev_long_start = (state == ST_HELD) && !ev_release && long_hit;
	assign ev_long_end = (state == ST_LONG) && ev_release;
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (ev_press) next_state = ST_HELD;
			ST_HELD: begin
				if (ev_release) next_state = ST_IDLE;
				else if (long_hit) next_state = ST_LONG; // R14
			end
			ST_LONG: if (ev_release) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) state <= ST_IDLE;
		else state <= next_state;
	end
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) press_ms <= 14'h0;
		else if (state != ST_HELD) press_ms <= 14'h0;
		else if (ms_tick && press_ms != 14'h3fff) press_ms <= press_ms + 14'h1;
	end

	assign cyc_limit = 25'(ctrl.cyc_value) * 25'(unit_s(ctrl.cyc_unit)); // R16

	// Per-object event reaction, present value and cyclic timer
	for (genvar i = 0; i < NUM_OBJ; i++) begin : g_obj
		logic f;
		logic arm;
		logic [31:0] v;
		logic [32:0] sa;
		logic [31:0] val;
		logic armed;
		logic [24:0] cnt;
		pbtl_data_point_type_t dt;
		always_comb begin
			dt = DTYPE_UNUSED;
			if (ctrl.advanced && obj_cfg[i].dtype <= DTYPE_F32) dt = obj_cfg[i].dtype; // R9 R1
			else if (ctrl.advanced) dt = DTYPE_UNUSED; // Spare code sends nothing
			else if (i == 0 && (ctrl.func == FUNC_SWITCH || ctrl.func == FUNC_DIM)) dt = DTYPE_SWITCH;
			else if (i == 1 && ctrl.func == FUNC_DIM) dt = DTYPE_DIMMING; // R8
		end
		always_comb begin
			f = 1'b0;
			arm = 1'b0;
			v = val;
			sa = {1'b0, val};
			if (ctrl.advanced && dt != DTYPE_UNUSED) begin
				if (ev_press && obj_cfg[i].press_send) begin // R2
					f = 1'b1;
					v = obj_cfg[i].press_toggle ? toggled(dt, val, obj_press_val[i]) // R3 R4
						: obj_press_val[i];
					arm = ctrl.cyc_en && obj_cfg[i].press_cyclic; // R5
				end else if (ev_release && obj_cfg[i].release_send) begin // R2
					f = 1'b1;
					v = obj_cfg[i].release_toggle ? toggled(dt, val, obj_rel_val[i]) // R3 R4
						: obj_rel_val[i];
					arm = ctrl.cyc_en && obj_cfg[i].release_cyclic; // R5
				end
			end else if (!ctrl.advanced && i == 0 && ctrl.func == FUNC_SWITCH) begin
				if (ev_press) sa = sw_act(simple.press_act, val); // R10
				else if (ev_release) sa = sw_act(simple.release_act, val); // R11
				f = sa[32];
				v = sa[31:0];
			end else if (!ctrl.advanced && i == 0 && ctrl.func == FUNC_DIM && ev_short) begin
				f = 1'b1; // R12
				case (simple.dim_react)
					DIM_ON_BRIGHTER: v = 32'h1;
					DIM_OFF_DARKER: v = 32'h0;
					default: v = {31'h0, ~val[0]};
				endcase
			end else if (!ctrl.advanced && i == 1 && ctrl.func == FUNC_DIM) begin
				if (ev_long_start) begin
					f = 1'b1; // R12
					case (simple.dim_react)
						DIM_ON_BRIGHTER, DIM_TOGGLE_BRIGHTER: v = {28'h0, 1'b1, DIM_STEP_START};
						DIM_OFF_DARKER, DIM_TOGGLE_DARKER: v = {28'h0, 1'b0, DIM_STEP_START};
						default: v = {28'h0, ~val[DIM_DIR_BIT], DIM_STEP_START}; // R15
					endcase
				end else if (ev_long_end) begin
					f = 1'b1; // R13
					v = {28'h0, val[DIM_DIR_BIT], DIM_STEP_BREAK};
				end
			end
		end
		always_ff @(posedge CLOCK or posedge RESET) begin
			if (RESET) val <= OBJ_VAL_RESET;
			else if (f) val <= v;
		end
		// Repeats are counted in whole seconds, so the first may come up to 1 s early
		always_ff @(posedge CLOCK or posedge RESET) begin
			if (RESET) begin
				armed <= 1'b0;
				cnt <= 25'h0;
			end else if (f) begin
				armed <= arm;
				cnt <= 25'h0;
			end else if (!ctrl.cyc_en || !ctrl.advanced) begin
				armed <= 1'b0;
			end else if (armed && sec_tick) begin
				cnt <= (cnt + 25'h1 >= cyc_limit) ? 25'h0 : cnt + 25'h1; // R5
			end
		end
		assign fire[i] = f;
		assign obj_value[i] = val;
		assign dtype_eff[i] = dt;
		assign cyc_armed[i] = armed;
		assign cyc_fire[i] = armed && ctrl.cyc_en && ctrl.advanced && sec_tick && !f
			&& (cnt + 25'h1 >= cyc_limit); // R5
	end

	// Lowest pending object is sent first
	always_comb begin
		sel = 2'h0;
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (pending[i]) sel = 2'(i);
		end
	end
	assign load = (!TX_VALID || TX_READY) && (pending != '0);

	// A new event wins over the clear of its pending flag
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			pending <= '0;
			pend_rep <= '0;
		end else begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				if (fire[i] || cyc_fire[i]) begin
					pending[i] <= 1'b1; // R2
					pend_rep[i] <= !fire[i];
				end else if (load && sel == 2'(i)) begin
					pending[i] <= 1'b0;
				end
			end
		end
	end

	// Telegram output register, held until the bus side accepts it
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			TX_VALID <= 1'b0;
			TX_TELEGRAM <= '0;
		end else if (load) begin
			TX_VALID <= 1'b1;
			TX_TELEGRAM <= {sel, dtype_eff[sel], pend_rep[sel], obj_value[sel]}; // R1
		end else if (TX_READY) begin
			TX_VALID <= 1'b0;
		end
	end

	a_dtype_valid: assert property (@(posedge CLOCK) disable iff (RESET) // R1
		TX_VALID |-> (TX_TELEGRAM.dtype != DTYPE_UNUSED && TX_TELEGRAM.dtype <= DTYPE_F32))
		else $error("telegram with bad data type");
	a_send_enabled: assert property (@(posedge CLOCK) disable iff (RESET) // R2
		(ctrl.advanced && ev_press && obj_cfg[0].press_send && dtype_eff[0] != DTYPE_UNUSED)
		|=> pending[0]
		&& (obj_value[0] == $past(obj_press_val[0]) || $past(obj_cfg[0].press_toggle)))
		else $error("enabled press telegram not queued");
	a_toggle_inverts: assert property (@(posedge CLOCK) disable iff (RESET) // R3
		(fire[0] && ctrl.advanced && obj_cfg[0].dtype == DTYPE_SWITCH && ev_press
		&& obj_cfg[0].press_toggle) |=> obj_value[0][0] != $past(obj_value[0][0]))
		else $error("toggle did not invert value");
	a_dim_alternate: assert property (@(posedge CLOCK) disable iff (RESET) // R15
		(!ctrl.advanced && ctrl.func == FUNC_DIM && simple.dim_react == DIM_TOGGLE_ALTERNATE
		&& ev_long_start) |=> obj_value[1][3] != $past(obj_value[1][3]) && obj_value[1][2:0] == 3'h1)
		else $error("dimming direction not reversed");
	a_cyclic_armed: assert property (@(posedge CLOCK) disable iff (RESET) // R5
		cyc_fire[0] |-> cyc_armed[0] && sec_tick && ctrl.cyc_en ##1 pending[0] && pend_rep[0])
		else $error("cyclic repeat without arming");
	a_block_hold: assert property (@(posedge CLOCK) disable iff (RESET) // R6
		!eval_on |-> fire == '0 && pending == '0 && state == ST_IDLE)
		else $error("input evaluated while blocked");
	a_block_release: assert property (@(posedge CLOCK) disable iff (RESET) // R7
		$rose(eval_on) |-> $past(!ctrl.blk_en || elapsed_s >= blk_limit))
		else $error("blocking ended early");
	a_switch_press: assert property (@(posedge CLOCK) disable iff (RESET) // R10
		(!ctrl.advanced && ctrl.func == FUNC_SWITCH && ev_press && simple.press_act == ACT_ON)
		|=> obj_value[0] == 32'h1 && pending[0])
		else $error("press on not sent");
	a_switch_release: assert property (@(posedge CLOCK) disable iff (RESET) // R11
		(!ctrl.advanced && ctrl.func == FUNC_SWITCH && ev_release && simple.release_act == ACT_OFF)
		|=> obj_value[0] == 32'h0 && pending[0])
		else $error("release off not sent");
	a_dim_break: assert property (@(posedge CLOCK) disable iff (RESET) // R13
		(!ctrl.advanced && ctrl.func == FUNC_DIM && ev_long_end)
		|=> pending[1] && obj_value[1][2:0] == DIM_STEP_BREAK)
		else $error("no break after long press");
	a_long_class: assert property (@(posedge CLOCK) disable iff (RESET) // R14
		(state == ST_HELD && next_state == ST_LONG) |-> ms_tick && press_ms == lp_ms)
		else $error("long press classified at wrong time");
	a_tick_gap: assert property (@(posedge CLOCK) disable iff (RESET) // R18
		ms_tick |=> !ms_tick ##0 tick_cnt == TW'(1))
		else $error("millisecond tick spacing wrong");
endmodule

//--- sim/pbtl_peer.sv
`timescale 1ns/100ps
module pbtl_peer (
	input wire logic clock,
	input wire logic reset,
	input wire logic slow,
	input wire logic tx_valid,
	input wire pbtl_pkg::pbtl_telegram_t tx_telegram,
	output logic tx_ready,
	output int n_got,
	output pbtl_pkg::pbtl_telegram_t last
);
	logic [1:0] stall;

	// Take each telegram; a slow peer then stalls three cycles, like a busy line
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stall <= 2'h0;
			n_got <= 0;
			last <= '0;
			tx_ready <= 1'b0;
		end else if (tx_valid && tx_ready) begin
			n_got <= n_got + 1;
			last <= tx_telegram;
			stall <= slow ? 2'h3 : 2'h0;
			tx_ready <= !slow;
		end else begin
			stall <= (stall != 2'h0) ? stall - 2'h1 : 2'h0;
			tx_ready <= (stall <= 2'h1);
		end
	end
endmodule

//--- sim/push_button_telegram_logic_bench.sv
`timescale 1ns/100ps
module push_button_telegram_logic_bench;
	import pbtl_pkg::*;
	// Start-up blocking on for 3 s, which is 48 cycles with the small ticks
	localparam logic [31:0] CTRL_BOOT = CTRL_RESET | 32'h0000_0020;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, button = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, tx_valid, tx_ready, er;
	pbtl_telegram_t tx_telegram, last;
	pbtl_ctrl_t c;
	int n_got, n_fail = 0, n_compared = 0;

	// Small tick counts: one ms is 4 cycles, one second 16 cycles
	always #2 clock = ~clock;

	pbtl_top #(.TICK_CYCLES_P(4), .MS_PER_SECOND_P(4), .DEBOUNCE_MS_P(2),
		.CTRL_INIT(CTRL_BOOT)) u_pbtl_top (
		.CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .BUTTON_IN(button), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_TELEGRAM(tx_telegram));
	pbtl_peer u_pbtl_peer (.clock(clock), .reset(reset), .slow(slow), .tx_valid(tx_valid),
		.tx_telegram(tx_telegram), .tx_ready(tx_ready), .n_got(n_got), .last(last));

	task report_and_stop;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	// One APB transfer; held until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && k < 50) begin
			k++;
			@(posedge clock);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_fail++;
			report_and_stop();
		end
	endtask

	// Set the button and wait for a telegram (want=1) or for silence (want=0)
	task push(input logic lvl, input logic want, input int lim);
		int n0, k;
		n0 = n_got;
		k = 0;
		@(posedge clock);
		button <= lvl;
		while (n_got == n0 && k < lim) begin
			k++;
			@(posedge clock);
		end
		#1;
		if (want && n_got == n0) begin
			n_fail++;
			report_and_stop();
		end
		chk(want ? (n_got == n0 + 1) : (n_got == n0), "telegram count");
	endtask

	// A press inside the blocking time stays silent; evaluation starts afterwards
	task t_block;
		push(1'b1, 1'b0, 30);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[0] === 1'b0, "evaluation not blocked");
		push(1'b0, 1'b0, 60);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[0] === 1'b1, "blocking never ended");
	endtask

	task t_regs;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd === CTRL_BOOT, "ctrl reset");
		apb(1'b0, ADDR_SIMPLE, 32'h0);
		chk(rd === SIMPLE_RESET, "simple reset");
		apb(1'b0, 8'h0c, 32'h0);
		chk(er === 1'b1, "unmapped not refused");
		apb(1'b1, ADDR_STATUS, 32'hffffffff);
		chk(er === 1'b1, "read-only write not refused");
		apb(1'b1, 8'h14, 32'h0000000e);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd === 32'h0000000e && er === 1'b0, "object type readback");
	endtask

	task t_switch;
		push(1'b1, 1'b1, 400);
		chk(last === {2'd0, DTYPE_SWITCH, 1'b0, 32'h1}, "toggle to on");
		push(1'b0, 1'b0, 400);
		push(1'b1, 1'b1, 400);
		chk(last === {2'd0, DTYPE_SWITCH, 1'b0, 32'h0}, "toggle to off");
		apb(1'b1, ADDR_SIMPLE, 32'h00000048);
		push(1'b0, 1'b1, 400);
		chk(last.value === 32'h1 && last.obj === 2'd0, "release on");
		push(1'b1, 1'b0, 400);
		push(1'b0, 1'b1, 400);
		// Press sends on, release sends off
		apb(1'b1, ADDR_SIMPLE, 32'h00000046);
		push(1'b1, 1'b1, 400);
		chk(last === {2'd0, DTYPE_SWITCH, 1'b0, 32'h1}, "press on");
		push(1'b0, 1'b1, 400);
		chk(last === {2'd0, DTYPE_SWITCH, 1'b0, 32'h0}, "release off");
	endtask

	task t_dim;
		logic d;
		c = CTRL_RESET;
		c.func = FUNC_DIM;
		c.long_sel = 5'h00;
		apb(1'b1, ADDR_CTRL, c);
		apb(1'b1, ADDR_SIMPLE, SIMPLE_RESET);
		push(1'b1, 1'b1, 8000);
		d = last.value[3];
		chk(last.obj === 2'd1 && last.value[2:0] === 3'h1, "dim start");
		push(1'b0, 1'b1, 400);
		chk(last.obj === 2'd1 && last.value[3:0] === {d, 3'h0}, "dim break");
		push(1'b1, 1'b1, 8000);
		chk(last.value[3:0] === {~d, 3'h1}, "direction reversed");
		push(1'b0, 1'b1, 400);
		chk(last.value[2:0] === 3'h0, "second break");
		// A 10 ms press is short: nothing on press, switch toggles on release
		push(1'b1, 1'b0, 40);
		push(1'b0, 1'b1, 400);
		chk(last === {2'd0, DTYPE_SWITCH, 1'b0, 32'h1}, "short press toggles");
	endtask

	// Object 1 unused and object 2 not sending, so only object 0 ever appears
	task t_cyclic;
		slow <= 1'b1;
		apb(1'b1, 8'h10, 32'h0000005c);
		apb(1'b1, 8'h20, 32'h00001234);
		apb(1'b1, 8'h14, 32'h00000010);
		apb(1'b1, 8'h18, 32'h00000001);
		c = CTRL_RESET;
		c.advanced = 1'b1;
		c.cyc_en = 1'b1;
		c.cyc_value = 8'h01;
		c.cyc_unit = TU_SECOND;
		apb(1'b1, ADDR_CTRL, c);
		push(1'b1, 1'b1, 400);
		chk(last === {2'd0, DTYPE_U16, 1'b0, 32'h1234}, "advanced press");
		push(1'b1, 1'b1, 200);
		chk(last === {2'd0, DTYPE_U16, 1'b1, 32'h1234}, "cyclic repeat");
	endtask

	initial begin
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		t_block();
		t_regs();
		t_switch();
		t_dim();
		t_cyclic();
		report_and_stop();
	end
endmodule
